/* src/mid_decoder.sv */
// decoder: opcode to operation class, length, cycle count and flag update
`timescale 1ns/10ps
module mid_decoder
  import mid_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic branch_taken,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] src_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  input wire logic aux_in,
  output logic [4:0] op_class,
  output logic [1:0] op_len,
  output logic [3:0] op_cycles,
  output logic [2:0] reg_num,
  output logic reg_sel,
  output logic [2:0] page_bits,
  output logic page_sel,
  output logic is_branch,
  output logic busy,
  output logic done,
  output logic [7:0] res_out,
  output logic [7:0] res_hi,
  output logic cy_out,
  output logic ac_out,
  output logic ov_out,
  output logic par_out
);

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  mid_op_t d_class;
  logic [1:0] d_len;
  logic [3:0] d_cyc;
  logic d_reg;
  logic d_page;
  logic d_brc;

  always_comb begin
    d_class = MID_OP_MISC;
    d_len = MID_LEN_1;
    d_cyc = MID_CYC_2;
    d_reg = 1'b0;
    d_page = 1'b0;
    d_brc = 1'b0;
    // low nibble 8..F selects Rn forms in every row that has them
    if (opcode[3] && opcode[7:4] != 4'hA && opcode[7:4] != 4'h8) begin
      d_reg = 1'b1;
    end
    if (opcode[3:0] == 4'h1) begin
      d_page = 1'b1;
      d_len = MID_LEN_2;
      d_cyc = MID_CYC_6;
      d_class = opcode[4] ? MID_OP_CALL : MID_OP_JMP;
    end else begin
      case (opcode[7:4])
        4'h2, 4'h3, 4'h9: begin
          d_class = (opcode[7:4] == 4'h2) ? MID_OP_ADD :
                    (opcode[7:4] == 4'h3) ? MID_OP_ADDC : MID_OP_SUBB;
          if (opcode[3:2] != 2'b00 || opcode[1]) begin
            d_len = (opcode[3:0] == 4'h5) ? MID_LEN_2 : MID_LEN_1;
          end
          if (opcode[3:0] == 4'h4) begin
            d_len = MID_LEN_2;
          end
          if (opcode[7:4] != 4'h9 && opcode[3:0] == 4'h2) begin
            d_class = MID_OP_RET;
            d_cyc = MID_CYC_6;
          end
          if (opcode[7:4] != 4'h9 && opcode[3:0] == 4'h3) begin
            d_class = MID_OP_ROT;
          end
          if (opcode[7:4] != 4'h9 && opcode[3:0] == 4'h0) begin
            d_class = MID_OP_BRC;
            d_len = MID_LEN_3;
            d_cyc = MID_CYC_4;
            d_brc = 1'b1;
          end
          if (opcode[7:4] == 4'h9 && opcode[3:0] == 4'h0) begin
            d_class = MID_OP_MOV;
            d_len = MID_LEN_3;
            d_cyc = MID_CYC_4;
          end
          if (opcode[7:4] == 4'h9 && opcode[3:0] == 4'h2) begin
            d_class = MID_OP_BIT;
            d_len = MID_LEN_2;
            d_cyc = MID_CYC_4;
          end
          if (opcode[7:4] == 4'h9 && opcode[3:0] == 4'h3) begin
            d_class = MID_OP_MOVC;
            d_cyc = MID_CYC_8;
          end
        end
        4'h0, 4'h1: begin
          d_class = opcode[4] ? MID_OP_DEC : MID_OP_INC;
          d_len = (opcode[3:0] == 4'h5) ? MID_LEN_2 : MID_LEN_1;
          case (opcode[3:0])
            4'h0: begin
              d_class = opcode[4] ? MID_OP_BRC : MID_OP_MISC;
              d_len = opcode[4] ? MID_LEN_3 : MID_LEN_1;
              d_cyc = opcode[4] ? MID_CYC_4 : MID_CYC_2;
              d_brc = opcode[4];
            end
            4'h2: begin
              d_class = opcode[4] ? MID_OP_CALL : MID_OP_JMP;
              d_len = MID_LEN_3;
              d_cyc = MID_CYC_6;
            end
            4'h3: d_class = MID_OP_ROT;
            default: begin
            end
          endcase
        end
        4'h4, 4'h5, 4'h6: begin
          d_class = (opcode[7:4] == 4'h4) ? MID_OP_ORL :
                    (opcode[7:4] == 4'h5) ? MID_OP_ANL : MID_OP_XRL;
          d_len = (opcode[3:0] == 4'h4 || opcode[3:0] == 4'h5 || opcode[3:0] == 4'h2) ? MID_LEN_2 : MID_LEN_1;
          if (opcode[3:0] == 4'h3) begin
            d_len = MID_LEN_3;
            d_cyc = MID_CYC_4;
          end
          if (opcode[3:0] == 4'h0) begin
            d_class = MID_OP_BRC;
            d_len = MID_LEN_2;
            d_cyc = MID_CYC_4;
            d_brc = 1'b1;
          end
        end
        4'h7: begin
          d_class = MID_OP_MOV;
          d_len = (opcode[3:0] == 4'h5) ? MID_LEN_3 : MID_LEN_2;
          if (opcode[3:0] == 4'h0) begin
            d_class = MID_OP_BRC;
            d_cyc = MID_CYC_4;
            d_brc = 1'b1;
          end else if (opcode[3:0] == 4'h2) begin
            d_class = MID_OP_BIT;
            d_cyc = MID_CYC_4;
          end else if (opcode[3:0] == 4'h3) begin
            d_class = MID_OP_JMP;
            d_len = MID_LEN_1;
            d_cyc = MID_CYC_6;
          end else if (opcode[3:0] == 4'h5) begin
            d_cyc = MID_CYC_4;
          end
        end
        4'h8: begin
          d_class = MID_OP_MOV;
          d_len = MID_LEN_2;
          d_cyc = MID_CYC_4;
          d_reg = opcode[3];
          case (opcode[3:0])
            4'h0: begin
              d_class = MID_OP_JMP;
              d_cyc = MID_CYC_6;
            end
            4'h2: d_class = MID_OP_BIT;
            4'h3: begin
              d_class = MID_OP_MOVC;
              d_len = MID_LEN_1;
              d_cyc = MID_CYC_8;
            end
            4'h4: begin
              d_class = MID_OP_DIV;
              d_len = MID_LEN_1;
              d_cyc = MID_CYC_8;
            end
            4'h5: d_len = MID_LEN_3;
            default: begin
            end
          endcase
        end
        4'hA: begin
          d_class = MID_OP_MOV;
          d_len = MID_LEN_2;
          d_cyc = MID_CYC_4;
          d_reg = opcode[3];
          case (opcode[3:0])
            4'h0: d_class = MID_OP_BIT;
            4'h2: begin
              d_class = MID_OP_BIT;
              d_cyc = MID_CYC_2;
            end
            4'h3: d_len = MID_LEN_1;
            4'h4: begin
              d_class = MID_OP_MUL;
              d_len = MID_LEN_1;
              d_cyc = MID_CYC_8;
            end
            default: begin
            end
          endcase
        end
        4'hB: begin
          d_class = MID_OP_BRC;
          d_len = MID_LEN_3;
          d_cyc = MID_CYC_4;
          d_brc = 1'b1;
          if (opcode[3:0] <= 4'h3) begin
            d_class = MID_OP_BIT;
            d_len = (opcode[3:0] == 4'h3) ? MID_LEN_1 : MID_LEN_2;
            d_cyc = (opcode[3:0] == 4'h0) ? MID_CYC_4 : MID_CYC_2;
            d_brc = 1'b0;
          end
        end
        4'hC, 4'hD: begin
          d_class = MID_OP_XCH;
          d_len = (opcode[3:0] == 4'h5) ? MID_LEN_2 : MID_LEN_1;
          if (opcode[3:0] == 4'h6 || opcode[3:0] == 4'h7) begin
            d_class = opcode[4] ? MID_OP_XCHD : MID_OP_XCH;
          end
          case (opcode[3:0])
            4'h0: begin
              d_class = MID_OP_STACK;
              d_len = MID_LEN_2;
              d_cyc = MID_CYC_4;
            end
            4'h2, 4'h3: begin
              d_class = MID_OP_BIT;
              d_len = opcode[0] ? MID_LEN_1 : MID_LEN_2;
            end
            4'h4: d_class = opcode[4] ? MID_OP_DA : MID_OP_ROT;
            4'h5: begin
              if (opcode[4]) begin
                d_class = MID_OP_BRC;
                d_len = MID_LEN_3;
                d_cyc = MID_CYC_4;
                d_brc = 1'b1;
              end
            end
            default: begin
              if (opcode[4] && opcode[3]) begin
                d_class = MID_OP_BRC;
                d_len = MID_LEN_2;
                d_cyc = MID_CYC_4;
                d_brc = 1'b1;
              end
            end
          endcase
        end
        default: begin
          d_class = MID_OP_MOV;
          d_len = (opcode[3:0] == 4'h5) ? MID_LEN_2 : MID_LEN_1;
          if (opcode[3:1] == 3'b001 || opcode[3:0] == 4'h0) begin
            d_class = MID_OP_MOVX;
            d_cyc = MID_CYC_8;
          end
          if (opcode[3:0] == 4'h4) begin
            d_class = MID_OP_MISC;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alu flag results
  // ----------------------------------------------------------------
  logic [8:0] a_sum;
  logic [4:0] a_nib;
  logic [15:0] a_prod;
  logic [7:0] a_res;
  logic [7:0] a_hi;
  logic a_cy;
  logic a_ac;
  logic a_ov;
  logic cin;

  always_comb begin
    cin = (d_class == MID_OP_ADD) ? 1'b0 : carry_in;
    a_sum = 9'h000;
    a_nib = 5'h00;
    a_prod = 16'h0000;
    a_res = acc_in;
    a_hi = b_in;
    a_cy = carry_in;
    a_ac = aux_in;
    a_ov = 1'b0;
    case (d_class)
      MID_OP_ADD, MID_OP_ADDC: begin
        a_sum = {1'b0, acc_in} + {1'b0, src_in} + {8'h00, cin};
        a_nib = {1'b0, acc_in[3:0]} + {1'b0, src_in[3:0]} + {4'h0, cin};
        a_res = a_sum[7:0];
        a_cy = a_sum[8];
        a_ac = a_nib[4];
        a_ov = (acc_in[7] == src_in[7]) && (a_res[7] != acc_in[7]);
      end
      MID_OP_SUBB: begin
        a_sum = {1'b0, acc_in} - {1'b0, src_in} - {8'h00, carry_in};
        a_nib = {1'b0, acc_in[3:0]} - {1'b0, src_in[3:0]} - {4'h0, carry_in};
        a_res = a_sum[7:0];
        a_cy = a_sum[8];
        a_ac = a_nib[4];
        a_ov = (acc_in[7] != src_in[7]) && (a_res[7] != acc_in[7]);
      end
      MID_OP_MUL: begin
        a_prod = acc_in * b_in;
        a_res = a_prod[7:0];
        a_hi = a_prod[15:8];
        a_cy = 1'b0;
        a_ov = (a_prod[15:8] != 8'h00);
      end
      MID_OP_DIV: begin
        a_cy = 1'b0;
        a_ov = (b_in == 8'h00);
        a_res = a_ov ? acc_in : acc_in / b_in;
        a_hi = a_ov ? b_in : acc_in % b_in;
      end
      MID_OP_DA: begin
        a_sum = {a_cy, acc_in};
        if (acc_in[3:0] > 4'h9 || aux_in) begin
          a_sum = a_sum + 9'h006;
        end
        if (a_sum[7:4] > 4'h9 || a_sum[8] || carry_in) begin
          a_sum = a_sum + 9'h060;
        end
        a_res = a_sum[7:0];
        a_cy = a_sum[8] | carry_in;
      end
      MID_OP_XCHD: a_res = {acc_in[7:4], src_in[3:0]};
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer: hold the decode for its cycle count
  // ----------------------------------------------------------------
  mid_state_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      MID_ST_IDLE: if (op_valid) begin
        nxt_st = MID_ST_EXEC;
        nxt_cnt = d_cyc - 4'h1;
      end
      MID_ST_EXEC: begin
        nxt_cnt = cnt_ff - 4'h1;
        // taken branch stretches by two cycles at the end
        if (cnt_ff == 4'h1) begin
          nxt_st = MID_ST_DONE;
        end
      end
      MID_ST_DONE: nxt_st = MID_ST_IDLE;
      default: nxt_st = MID_ST_IDLE;
    endcase
  end

  logic [4:0] nxt_class;
  logic [1:0] nxt_len;
  logic [3:0] nxt_cyc;
  logic taken_add;
  always_comb begin
    taken_add = (st_ff == MID_ST_EXEC) && cnt_ff == 4'h1 && is_branch && branch_taken && op_cycles == MID_CYC_4;
    nxt_class = (st_ff == MID_ST_IDLE && op_valid) ? d_class : op_class;
    nxt_len = (st_ff == MID_ST_IDLE && op_valid) ? d_len : op_len;
    nxt_cyc = (st_ff == MID_ST_IDLE && op_valid) ? d_cyc : (taken_add ? MID_CYC_6 : op_cycles);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= MID_ST_IDLE;
      cnt_ff <= 4'h0;
      op_class <= 5'h00;
      op_len <= MID_LEN_RST;
      op_cycles <= MID_CYC_RST;
      reg_num <= 3'h0;
      reg_sel <= 1'b0;
      page_bits <= 3'h0;
      page_sel <= 1'b0;
      is_branch <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      res_out <= 8'h00;
      res_hi <= 8'h00;
      cy_out <= 1'b0;
      ac_out <= 1'b0;
      ov_out <= 1'b0;
      par_out <= 1'b0;
    end else begin
      st_ff <= taken_add ? MID_ST_EXEC : nxt_st;
      cnt_ff <= taken_add ? 4'h2 : nxt_cnt;
      op_class <= nxt_class;
      op_len <= nxt_len;
      op_cycles <= nxt_cyc;
      busy <= (nxt_st == MID_ST_EXEC) || taken_add;
      done <= (nxt_st == MID_ST_DONE) && !taken_add;
      if (st_ff == MID_ST_IDLE && op_valid) begin
        reg_num <= opcode[MID_REG_LSB +: 3];
        reg_sel <= d_reg;
        page_bits <= opcode[MID_PAGE_LSB +: 3];
        page_sel <= d_page;
        is_branch <= d_brc;
        res_out <= a_res;
        res_hi <= a_hi;
        cy_out <= a_cy;
        ac_out <= a_ac;
        ov_out <= a_ov;
        par_out <= ^a_res;
      end
    end
  end

endmodule // mid_decoder

/* src/mid_pkg.sv */
// package: opcode decode constants, operation classes and timing figures
package mid_pkg;
  localparam logic [1:0] MID_LEN_RST = 2'h1;
  localparam logic [3:0] MID_CYC_RST = 4'h2;
  localparam logic [3:0] MID_CYC_2 = 4'h2;
  localparam logic [3:0] MID_CYC_4 = 4'h4;
  localparam logic [3:0] MID_CYC_6 = 4'h6;
  localparam logic [3:0] MID_CYC_8 = 4'h8;
  localparam logic [1:0] MID_LEN_1 = 2'h1;
  localparam logic [1:0] MID_LEN_2 = 2'h2;
  localparam logic [1:0] MID_LEN_3 = 2'h3;
  localparam int MID_REG_LSB = 0;
  localparam int MID_PAGE_LSB = 5;

  typedef enum logic [4:0] {
    MID_OP_MISC  = 5'h00,
    MID_OP_ADD   = 5'h01,
    MID_OP_ADDC  = 5'h02,
    MID_OP_SUBB  = 5'h03,
    MID_OP_INC   = 5'h04,
    MID_OP_DEC   = 5'h05,
    MID_OP_MUL   = 5'h06,
    MID_OP_DIV   = 5'h07,
    MID_OP_DA    = 5'h08,
    MID_OP_ANL   = 5'h09,
    MID_OP_ORL   = 5'h0A,
    MID_OP_XRL   = 5'h0B,
    MID_OP_ROT   = 5'h0C,
    MID_OP_MOV   = 5'h0D,
    MID_OP_MOVC  = 5'h0E,
    MID_OP_MOVX  = 5'h0F,
    MID_OP_STACK = 5'h10,
    MID_OP_XCH   = 5'h11,
    MID_OP_XCHD  = 5'h12,
    MID_OP_BIT   = 5'h13,
    MID_OP_JMP   = 5'h14,
    MID_OP_CALL  = 5'h15,
    MID_OP_RET   = 5'h16,
    MID_OP_BRC   = 5'h17
  } mid_op_t;

  typedef enum logic [2:0] {
    MID_ST_IDLE = 3'b001,
    MID_ST_EXEC = 3'b010,
    MID_ST_DONE = 3'b100
  } mid_state_t;
endpackage

/* testbench/mcu_instruction_decoder_timing_bench.sv */
// bench: opcode table sweep, refused request, flags and mid-run reset
`timescale 1ns/10ps
module mcu_instruction_decoder_timing_bench;
  import mid_pkg::*;
  typedef struct packed {logic [7:0] op; logic [1:0] len; logic [3:0] cyc; logic tk;} mid_row_t;
  // rows follow the code image of the program memory model
  localparam mid_row_t ROWS [27] = '{
    '{8'h24, 2'h2, 4'h2, 1'b0}, '{8'h2D, 2'h1, 4'h2, 1'b0}, '{8'h35, 2'h2, 4'h2, 1'b0},
    '{8'h9A, 2'h1, 4'h2, 1'b0}, '{8'h04, 2'h1, 4'h2, 1'b0}, '{8'h93, 2'h1, 4'h8, 1'b0},
    '{8'hE0, 2'h1, 4'h8, 1'b0}, '{8'h53, 2'h3, 4'h4, 1'b0}, '{8'h43, 2'h3, 4'h4, 1'b0},
    '{8'h63, 2'h3, 4'h4, 1'b0}, '{8'h33, 2'h1, 4'h2, 1'b0}, '{8'h85, 2'h3, 4'h4, 1'b0},
    '{8'h90, 2'h3, 4'h4, 1'b0}, '{8'hD0, 2'h2, 4'h4, 1'b0}, '{8'hD6, 2'h1, 4'h2, 1'b0},
    '{8'h82, 2'h2, 4'h4, 1'b0}, '{8'hA0, 2'h2, 4'h4, 1'b0}, '{8'h92, 2'h2, 4'h4, 1'b0},
    '{8'hA2, 2'h2, 4'h2, 1'b0}, '{8'h12, 2'h3, 4'h6, 1'b0}, '{8'h32, 2'h1, 4'h6, 1'b0},
    '{8'h71, 2'h2, 4'h6, 1'b0}, '{8'hB9, 2'h3, 4'h4, 1'b0}, '{8'hDF, 2'h2, 4'h6, 1'b1},
    '{8'hA4, 2'h1, 4'h8, 1'b0}, '{8'h14, 2'h1, 4'h2, 1'b0}, '{8'h73, 2'h1, 4'h6, 1'b0}};
  logic clk, arst_n, op_valid, branch_taken, carry_in, aux_in;
  logic [4:0] pc;
  logic [7:0] opcode, acc_in, src_in, b_in, res_out, res_hi;
  logic [4:0] op_class;
  logic [1:0] op_len;
  logic [3:0] op_cycles;
  logic [2:0] reg_num, page_bits;
  logic reg_sel, page_sel, is_branch, busy, done, cy_out, ac_out, ov_out, par_out;
  int fails, total_checks, k, i;

  mid_prog_mem prog_mem (.addr(pc), .rdata(opcode));
  mid_decoder DUT (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .opcode(opcode), .branch_taken(branch_taken),
    .acc_in(acc_in), .src_in(src_in), .b_in(b_in), .carry_in(carry_in), .aux_in(aux_in), .op_class(op_class),
    .op_len(op_len), .op_cycles(op_cycles), .reg_num(reg_num), .reg_sel(reg_sel), .page_bits(page_bits),
    .page_sel(page_sel), .is_branch(is_branch), .busy(busy), .done(done), .res_out(res_out), .res_hi(res_hi),
    .cy_out(cy_out), .ac_out(ac_out), .ov_out(ov_out), .par_out(par_out));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // k counts cycles from the taking edge to the done cycle; hold keeps requesting while busy
  task automatic run_op(input logic [4:0] a, input logic tk, input logic hold);
    @(posedge clk);
    pc <= a;
    branch_taken <= tk;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= hold;
    pc <= 5'h1F;
    #1;
    k = 1;
    while (done !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    op_valid <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // --------------------------------
  // sequence
  // --------------------------------
  initial begin
    arst_n = 1'b0;
    op_valid = 1'b0;
    pc = 5'h00;
    branch_taken = 1'b0;
    acc_in = 8'h00;
    src_in = 8'h00;
    b_in = 8'h00;
    carry_in = 1'b0;
    aux_in = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 27; i++) begin
      run_op(i[4:0], ROWS[i].tk, 1'b0);
      chk("op_len", {6'h00, ROWS[i].len}, {6'h00, op_len});
      chk("op_cycles", {4'h0, ROWS[i].cyc}, {4'h0, op_cycles});
      chk("cycle count", {4'h0, ROWS[i].cyc}, k[7:0]);
      chk("reg_num", {5'h00, ROWS[i].op[2:0]}, {5'h00, reg_num});
      chk("page_bits", {5'h00, ROWS[i].op[7:5]}, {5'h00, page_bits});
      chk("reg_sel", {7'h00, ROWS[i].op[3]}, {7'h00, reg_sel});
      chk("page_sel", {7'h00, (ROWS[i].op[3:0] == 4'h1)}, {7'h00, page_sel});
    end
    // request held high while busy must be ignored, not restart the code read
    run_op(5'd5, 1'b0, 1'b1);
    chk("held cycles", 8'h08, k[7:0]);
    // signed overflow with carry out
    acc_in <= 8'h80;
    src_in <= 8'h80;
    run_op(5'd0, 1'b0, 1'b0);
    chk("add flags", 8'h0C, {4'h0, cy_out, ov_out, ac_out, par_out});
    chk("add result", 8'h00, res_out);
    // borrow through both nibbles
    acc_in <= 8'h00;
    src_in <= 8'h01;
    run_op(5'd3, 1'b0, 1'b0);
    chk("subb flags", 8'h0A, {4'h0, cy_out, ov_out, ac_out, par_out});
    chk("subb result", 8'hFF, res_out);
    // product above one byte sets overflow and leaves the high byte aside
    acc_in <= 8'h10;
    b_in <= 8'h20;
    run_op(5'd24, 1'b0, 1'b0);
    chk("mul class", {3'h0, MID_OP_MUL}, {3'h0, op_class});
    chk("mul high", 8'h02, res_hi);
    chk("mul flags", 8'h04, {4'h0, cy_out, ov_out, 2'b00});
    // quotient and remainder
    acc_in <= 8'h17;
    b_in <= 8'h05;
    run_op(5'd27, 1'b0, 1'b0);
    chk("div result", 8'h04, res_out);
    chk("div remainder", 8'h03, res_hi);
    chk("div cycles", 8'h08, k[7:0]);
    // decimal adjust carrying out of the high digit
    acc_in <= 8'h9A;
    run_op(5'd28, 1'b0, 1'b0);
    chk("da result", 8'h00, res_out);
    chk("da carry", 8'h01, {7'h00, cy_out});
    // only the low nibble moves
    acc_in <= 8'hAB;
    src_in <= 8'hCD;
    run_op(5'd14, 1'b0, 1'b0);
    chk("nibble exchange", 8'hAD, res_out);
    // second reset while an eight-cycle read is under way, then a taken branch at once
    pc <= 5'd5;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset state", {MID_LEN_RST, MID_CYC_RST, 2'b00}, {op_len, op_cycles, busy, done});
    @(posedge clk);
    arst_n <= 1'b1;
    run_op(5'd23, 1'b1, 1'b0);
    chk("taken cycles", 8'h06, k[7:0]);
    close_out();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule // mcu_instruction_decoder_timing_bench

/* testbench/mid_decoder_sva.sv */
// checker: decode and timing relations seen at the decoder ports
`timescale 1ns/10ps
module mid_decoder_sva
  import mid_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [1:0] op_len,
  input wire logic [3:0] op_cycles,
  input wire logic [2:0] reg_num,
  input wire logic [2:0] page_bits,
  input wire logic page_sel,
  input wire logic is_branch,
  input wire logic busy,
  input wire logic done
);
  // request is only taken while idle
  logic take;
  assign take = op_valid && !busy && !done;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // --------------------------------
  // assertions
  // --------------------------------
  start_busy_a: assert property (take |=> busy)
    else $error("busy missing after request");
  pulse_end_a: assert property (done |=> !done && !busy)
    else $error("done longer than one cycle");
  size_range_a: assert property (done |-> op_len >= MID_LEN_1 && op_cycles >= MID_CYC_2 && op_cycles <= MID_CYC_8)
    else $error("length or cycles out of range");
  reg_field_a: assert property (take |=> reg_num == $past(opcode[2:0]))
    else $error("register number wrong");
  page_field_a: assert property (take && opcode[3:0] == 4'h1 |=> page_sel && page_bits == $past(opcode[7:5]))
    else $error("absolute page bits wrong");
  add_timing_a: assert property (take && opcode inside {[8'h24:8'h2F], [8'h34:8'h3F], [8'h94:8'h9F]}
    |=> op_cycles == MID_CYC_2 ##1 done)
    else $error("arithmetic timing wrong");
  long_ops_a: assert property (take && opcode inside {8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}
    |=> busy [*7] ##1 done)
    else $error("eight cycle op timing wrong");
  three_byte_a: assert property (take && opcode inside {8'h53, 8'h43, 8'h63, 8'h85, 8'h90}
    |=> op_len == MID_LEN_3 && op_cycles == MID_CYC_4)
    else $error("three byte op decode wrong");
  rotate_a: assert property (take && opcode inside {8'h03, 8'h13, 8'h23, 8'h33}
    |=> op_len == MID_LEN_1 && op_cycles == MID_CYC_2)
    else $error("rotate decode wrong");
  call_time_a: assert property (take && opcode inside {8'h12, 8'h22, 8'h32, 8'h73}
    |=> busy [*5] ##1 done)
    else $error("call or return timing wrong");
  branch_time_a: assert property (take && opcode inside {[8'hB4:8'hBF], [8'hD8:8'hDF]}
    |=> is_branch && op_cycles == MID_CYC_4)
    else $error("branch base timing wrong");
  cover property (take && opcode == 8'h93);
  cover property (is_branch && done && op_cycles == MID_CYC_6);
  cover property (take && opcode[3:0] == 4'h1);
endmodule // mid_decoder_sva

bind mid_decoder mid_decoder_sva u_sva (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .opcode(opcode),
  .op_len(op_len), .op_cycles(op_cycles), .reg_num(reg_num), .page_bits(page_bits), .page_sel(page_sel),
  .is_branch(is_branch), .busy(busy), .done(done));

/* testbench/mid_prog_mem.sv */
// partner: program memory holding the opcode stream for the decoder
`timescale 1ns/10ps
module mid_prog_mem (
  input wire logic [4:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] rom [32];
  // fixed code image; spare slots hold no-operation so a stray fetch is harmless
  initial begin
    rom = '{8'h24, 8'h2D, 8'h35, 8'h9A, 8'h04, 8'h93, 8'hE0, 8'h53, 8'h43, 8'h63, 8'h33, 8'h85, 8'h90,
      8'hD0, 8'hD6, 8'h82, 8'hA0, 8'h92, 8'hA2, 8'h12, 8'h32, 8'h71, 8'hB9, 8'hDF, 8'hA4, 8'h14, 8'h73,
      8'h84, 8'hD4, 8'h00, 8'h00, 8'h00};
  end
  assign rdata = rom[addr];
endmodule // mid_prog_mem
